// *** verification/lsb_rf_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// register-file side: keeps the last written destination and the carry flag
module lsb_rf_model
    import lsb_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // result from the datapath
    input  wire logic        i_valid,
    input  wire logic [31:0] i_result,
    input  wire logic        i_carry,
    input  wire logic        i_carry_we,
    // state fed back to the next request
    output logic      [31:0] o_reg,
    output logic             o_flag
);
    // flag moves only on shift-class writes, so logic ops cannot corrupt it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg  <= 32'h0;
            o_flag <= 1'b0;
        end else if (i_valid) begin
            o_reg <= i_result;
            if (i_carry_we) begin
                o_flag <= i_carry;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lsb_pkg::*;
;
    // request fields, all driven on the falling edge
    logic        clk = 0, rst_b = 0, vld = 0, use_imm = 0, from_reg = 0, c = 0, use_fb = 0;
    logic [3:0]  op = 4'h0;
    logic [1:0]  sz = 2'h0;
    logic [31:0] d = 32'h0, s = 32'h0, imm = 32'h0;
    logic [2:0]  bimm = 3'h0;
    wire logic        ov, oc, owe, rf_c;
    wire logic [31:0] res, rf_d;
    // chained rotates take the carry back from the register file
    wire logic        cin = use_fb ? rf_c : c;
    int               n_mismatch = 0, checks_done = 0;

    always #5 clk = ~clk;

    lsb_alu i_lsb_alu (.i_clk(clk), .i_rst_b(rst_b), .i_valid(vld), .i_op(op), .i_size(sz), .i_dest(d),
        .i_source_register(s), .i_imm(imm), .i_use_imm(use_imm), .i_bit_imm(bimm), .i_bit_from_reg(from_reg),
        .i_carry(cin), .o_valid(ov), .o_result(res), .o_carry(oc), .o_carry_we(owe));
    lsb_rf_model i_lsb_rf_model (.i_clk(clk), .i_rst_b(rst_b), .i_valid(ov), .i_result(res), .i_carry(oc),
        .i_carry_we(owe), .o_reg(rf_d), .o_flag(rf_c));

    // expected carry and result of a logic, shift or rotate request
    function automatic logic [32:0] ref_f(input logic [3:0] o, input logic [1:0] z,
                                          input logic [31:0] dv, input logic [31:0] sv, input logic ci);
        logic [31:0] m, top, r;
        logic        hi, fill;
        m    = z == LSB_SIZE_BYTE ? 32'hff : z == LSB_SIZE_WORD ? 32'hffff : 32'hffff_ffff;
        top  = m & ~(m >> 1);
        dv   = dv & m;
        hi   = |(dv & top);
        fill = o == LSB_OP_ARITH_SHIFT_RIGHT_OP ? hi : (o | 4'h1) == LSB_OP_ROTATE_RIGHT_OP ? (o[0] ? dv[0] : hi)
             : (o | 4'h1) == LSB_OP_ROTATE_RIGHT_CARRY_OP && ci;
        case (o)
            LSB_OP_AND: r = dv & sv;
            LSB_OP_OR:  r = dv | sv;
            LSB_OP_XOR: r = dv ^ sv;
            LSB_OP_NOT: r = ~dv;
            default:    r = (o[0] ? dv >> 1 : dv << 1) | (fill ? (o[0] ? top : 32'h1) : 32'h0);
        endcase
        return {o < 4'h4 ? ci : o[0] ? dv[0] : hi, r & m};
    endfunction

    task chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one request on a falling edge, answer one cycle later; an idle cycle follows so the strobe never flips twice at once
    task issue(input logic [3:0] o, input logic [1:0] z, input logic [31:0] dv, input logic [31:0] sv);
        op  = o;
        sz  = z;
        d   = dv;
        s   = sv;
        vld = 1;
        @(negedge clk);
        vld = 0;
        chk({31'h0, ov, owe}, {31'h0, 1'b1, o >= 4'h4 && o <= 4'hb});
        @(negedge clk);
    endtask

    // every logic op, size and operand source; upper dest bits set to catch width leaks
    task t_logic;
        for (int k = 0; k < 4; k++)
            for (int z = 0; z < 3; z++)
                for (int u = 0; u < 2; u++) begin
                    use_imm = u[0];
                    imm     = 32'hc3a5_9617;
                    c       = z[0];
                    issue(k[3:0], z[1:0], 32'hf0f0_5a3c, 32'h3c3c_0ff0);
                    chk({oc, res}, ref_f(k[3:0], z[1:0], 32'hf0f0_5a3c, u ? imm : 32'h3c3c_0ff0, c));
                end
    endtask

    // carry chosen opposite to the edge bits so plain and carry rotates differ
    task t_shift;
        for (int k = 4; k < 12; k++)
            for (int z = 0; z < 3; z++)
                for (int j = 0; j < 2; j++) begin
                    c = ~j[0];
                    issue(k[3:0], z[1:0], j ? 32'h8001_8081 : 32'h7ffe_7f7e, 32'h0);
                    chk({oc, res}, ref_f(k[3:0], z[1:0], j ? 32'h8001_8081 : 32'h7ffe_7f7e, 32'h0, c));
                end
    endtask

    // the unused bit-number source always points elsewhere
    task t_bits;
        logic [7:0] e;
        c = 1;
        for (int k = 0; k < 2; k++)
            for (int b = 0; b < 8; b++)
                for (int r = 0; r < 2; r++) begin
                    from_reg = r[0];
                    bimm     = r[0] ? ~b[2:0] : b[2:0];
                    e        = k[0] ? 8'h5a & ~(8'h1 << b) : 8'h5a | (8'h1 << b);
                    issue(k[0] ? LSB_OP_BIT_CLEAR_OP : LSB_OP_BIT_SET_OP, LSB_SIZE_LONG, 32'hc3a5_965a,
                          {29'h1234_5678, r[0] ? b[2:0] : ~b[2:0]});
                    chk({oc, res}, {c, 24'h0, e});
                end
        from_reg = 0;
    endtask

    // nine rotates through carry bring a byte and its carry back to the start
    task t_chain;
        logic [32:0] e;
        use_fb = 1;
        issue(LSB_OP_LOGIC_SHIFT_RIGHT_OP, LSB_SIZE_BYTE, 32'h1, 32'h0);
        e = {1'b1, 32'h0};
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            chk({rf_c, rf_d}, e);
            issue(LSB_OP_ROTATE_RIGHT_CARRY_OP, LSB_SIZE_BYTE, rf_d, 32'h0);
            e = ref_f(LSB_OP_ROTATE_RIGHT_CARRY_OP, LSB_SIZE_BYTE, e[31:0], 32'h0, e[32]);
        end
        @(negedge clk);
        chk({rf_c, rf_d}, {1'b1, 32'h0});
        use_fb = 0;
    endtask

    // strobe held high for two requests, then the result must hold
    task t_b2b;
        op      = LSB_OP_XOR;
        sz      = LSB_SIZE_BYTE;
        d       = 32'h0000_00ff;
        s       = 32'h0000_000f;
        use_imm = 0;
        vld     = 1;
        @(negedge clk);
        chk({ov, res}, {1'b1, 32'h0000_00f0});
        op = LSB_OP_NOT;
        sz = LSB_SIZE_WORD;
        d  = 32'h0001_1234;
        @(negedge clk);
        vld = 0;
        chk({ov, res}, {1'b1, 32'h0000_edcb});
        @(negedge clk);
        chk({ov, res}, {1'b0, 32'h0000_edcb});
    endtask

    // mid-run reset clears the outputs at once
    task t_reset;
        issue(LSB_OP_NOT, LSB_SIZE_LONG, 32'h0, 32'h0);
        rst_b = 0;
        #1;
        chk({ov, owe, res[30:0]}, 33'h0);
        @(negedge clk);
        rst_b = 1;
        @(negedge clk);
    endtask

    // main sequence after 8 cycles of reset
    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1;
        @(negedge clk);
        t_logic;
        t_shift;
        t_bits;
        t_chain;
        t_b2b;
        t_reset;
        t_shift;
        give_verdict;
    end

    // 165 requests in about 350 cycles are needed; 5000 cycles leaves a wide margin
    initial begin
        #50000;
        n_mismatch++;
        give_verdict;
    end
endmodule
`default_nettype wire

// *** verilog/lsb_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: AND destination with register or immediate
// RQ2: OR destination with register or immediate
// RQ3: XOR destination with register or immediate
// RQ4: NOT inverts every destination bit
// RQ5: byte, word or longword size selectable
// RQ6: arithmetic shifts left and right
// RQ7: logical shifts left and right
// RQ8: rotate left and right within width
// RQ9: rotate through carry as extra bit
// RQ10: bit set forces selected byte bit
// RQ11: bit clear zeroes selected byte bit
// RQ12: bit number from immediate or register
// RQ13: operands viewed as 8/16/32-bit registers
// RQ14: shifted-out bit goes to carry flag
module lsb_alu
    import lsb_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // request from decoder
    input  wire logic        i_valid,
    input  wire logic [3:0]  i_op,
    input  wire logic [1:0]  i_size,
    input  wire logic [31:0] i_dest,
    input  wire logic [31:0] i_source_register,
    input  wire logic [31:0] i_imm,
    input  wire logic        i_use_imm,
    input  wire logic [2:0]  i_bit_imm,
    input  wire logic        i_bit_from_reg,
    input  wire logic        i_carry,
    // result to register file and condition code register
    output logic             o_valid,
    output logic [31:0]      o_result,
    output logic             o_carry,
    output logic             o_carry_we
);

    // keep only the bits of the selected size [RQ5] [RQ13]
    function automatic logic [31:0] size_mask(input logic [1:0] sz, input logic [31:0] v);
        unique case (sz)
            LSB_SIZE_BYTE: size_mask = {24'h00_0000, v[7:0]};
            LSB_SIZE_WORD: size_mask = {16'h0000, v[15:0]};
            default:       size_mask = v;
        endcase
    endfunction

    logic [31:0] dst;
    logic [31:0] src;
    logic [31:0] sh_val;
    logic        sh_carry;
    logic [2:0]  bitno;
    logic [7:0]  bit_one;
    logic        is_shift;
    logic [31:0] next_result;
    logic        next_carry;

    // operands trimmed to width; upper bits of a narrow view are not produced
    assign dst = size_mask(i_size, i_dest);                                  // [RQ13]
    assign src = size_mask(i_size, i_use_imm ? i_imm : i_source_register);   // [RQ1] [RQ2] [RQ3]

    // bit number source select
    assign bitno   = i_bit_from_reg ? i_source_register[2:0] : i_bit_imm;   // [RQ12]
    assign bit_one = 8'h01 << bitno;

    assign is_shift = (i_op >= LSB_OP_ARITH_SHIFT_LEFT_OP) && (i_op <= LSB_OP_ROTATE_RIGHT_CARRY_OP);

    lsb_shifter u_shift (
        .i_val   (dst),
        .i_size  (i_size),
        .i_op    (i_op),
        .i_carry (i_carry),
        .o_val   (sh_val),
        .o_carry (sh_carry)
    );

    // result mux
    always_comb begin
        next_carry = i_carry;
        unique case (i_op)
            LSB_OP_AND:          next_result = dst & src;                        // [RQ1]
            LSB_OP_OR:           next_result = dst | src;                        // [RQ2]
            LSB_OP_XOR:          next_result = dst ^ src;                        // [RQ3]
            LSB_OP_NOT:          next_result = size_mask(i_size, ~i_dest);       // [RQ4]
            LSB_OP_BIT_SET_OP:   next_result = {24'h00_0000, i_dest[7:0] | bit_one};  // [RQ10]
            LSB_OP_BIT_CLEAR_OP: next_result = {24'h00_0000, i_dest[7:0] & ~bit_one}; // [RQ11]
            default: begin
                // left shifts push the top bit past the operand edge; trim it back [RQ5]
                next_result = size_mask(i_size, sh_val);                          // [RQ6] [RQ7] [RQ8]
                next_carry  = sh_carry;                                           // [RQ9] [RQ14]
            end
        endcase
    end

    // registered result; one cycle latency
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_valid    <= 1'b0;
            o_result   <= LSB_RESULT_RST;
            o_carry    <= LSB_CARRY_RST;
            o_carry_we <= 1'b0;
        end else begin
            o_valid    <= i_valid;
            o_carry_we <= i_valid && is_shift;
            if (i_valid) begin
                o_result <= next_result;
                o_carry  <= next_carry;
            end
        end
    end

    // independent view of operand and width, kept apart from the datapath wiring
    logic [31:0] chk_mask;
    logic [31:0] chk_src;
    assign chk_mask = (i_size == LSB_SIZE_BYTE) ? 32'h0000_00ff
                    : (i_size == LSB_SIZE_WORD) ? 32'h0000_ffff
                    : 32'hffff_ffff;
    assign chk_src  = i_use_imm ? i_imm : i_source_register;

    // checks
    and_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ1]
        i_valid && i_op == LSB_OP_AND |=> o_result == ($past(i_dest) & $past(chk_src) & $past(chk_mask)))
        else $error("and result wrong");
    or_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ2]
        i_valid && i_op == LSB_OP_OR |=> o_result == (($past(i_dest) | $past(chk_src)) & $past(chk_mask)))
        else $error("or result wrong");
    xor_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ3]
        i_valid && i_op == LSB_OP_XOR |=> o_result == (($past(i_dest) ^ $past(chk_src)) & $past(chk_mask)))
        else $error("xor result wrong");
    not_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ4]
        i_valid && i_op == LSB_OP_NOT && i_size == LSB_SIZE_BYTE |=> o_result[7:0] == ~$past(i_dest[7:0]))
        else $error("not result wrong");
    byte_width_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ5]
        i_valid && i_size == LSB_SIZE_BYTE |=> o_result[31:8] == 24'h00_0000)
        else $error("byte result has upper bits");
    asr_sign_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ6]
        i_valid && i_op == LSB_OP_ARITH_SHIFT_RIGHT_OP && i_size == LSB_SIZE_BYTE
        |=> o_result[7] == $past(i_dest[7]) && o_result[6:0] == $past(i_dest[7:1]))
        else $error("arith right shift wrong");
    lsr_fill_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ7]
        i_valid && i_op == LSB_OP_LOGIC_SHIFT_RIGHT_OP && i_size == LSB_SIZE_WORD
        |=> o_result[15:0] == {1'b0, $past(i_dest[15:1])})
        else $error("logic right shift wrong");
    rotate_left_op_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ8]
        i_valid && i_op == LSB_OP_ROTATE_LEFT_OP && i_size == LSB_SIZE_LONG
        |=> o_result == {$past(i_dest[30:0]), $past(i_dest[31])})
        else $error("rotate left wrong");
    rotate_right_carry_op_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ9]
        i_valid && i_op == LSB_OP_ROTATE_RIGHT_CARRY_OP && i_size == LSB_SIZE_BYTE
        |=> o_result[7:0] == {$past(i_carry), $past(i_dest[7:1])} && o_carry == $past(i_dest[0]))
        else $error("rotate through carry wrong");
    bit_set_op_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ10]
        i_valid && i_op == LSB_OP_BIT_SET_OP |=> o_result[$past(bitno)] == 1'b1)
        else $error("bit set failed");
    bit_clear_op_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ11]
        i_valid && i_op == LSB_OP_BIT_CLEAR_OP |=> o_result[$past(bitno)] == 1'b0)
        else $error("bit clear failed");
    bit_reg_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ12]
        i_valid && i_op == LSB_OP_BIT_SET_OP && i_bit_from_reg
        |=> o_result[$past(i_source_register[2:0])] == 1'b1)
        else $error("register bit number ignored");
    shl_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ14]
        i_valid && i_op == LSB_OP_LOGIC_SHIFT_LEFT_OP && i_size == LSB_SIZE_WORD
        |=> o_carry == $past(i_dest[15]) && o_carry_we)
        else $error("carry not captured");
    word_view_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ13]
        i_valid && i_size == LSB_SIZE_WORD |=> o_result[31:16] == 16'h0000)
        else $error("word result has upper bits");

    // complement at the wider sizes
    not_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ4]
        i_valid && i_op == LSB_OP_NOT && i_size == LSB_SIZE_WORD
        |=> o_result == {16'h0000, ~$past(i_dest[15:0])})
        else $error("word not result wrong");

    not_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ4]
        i_valid && i_op == LSB_OP_NOT && i_size == LSB_SIZE_LONG
        |=> o_result == ~$past(i_dest))
        else $error("long not result wrong");

    // arithmetic shifts: zero fill on the left, sign kept on the right
    asl_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ6]
        i_valid && i_op == LSB_OP_ARITH_SHIFT_LEFT_OP && i_size == LSB_SIZE_BYTE
        |=> o_result == {24'h00_0000, $past(i_dest[6:0]), 1'b0}
            && o_carry == $past(i_dest[7]))
        else $error("arith left shift wrong");

    asr_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ6]
        i_valid && i_op == LSB_OP_ARITH_SHIFT_RIGHT_OP && i_size == LSB_SIZE_LONG
        |=> o_result == {$past(i_dest[31]), $past(i_dest[31:1])}
            && o_carry == $past(i_dest[0]))
        else $error("long arith right shift wrong");

    asr_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ6]
        i_valid && i_op == LSB_OP_ARITH_SHIFT_RIGHT_OP && i_size == LSB_SIZE_WORD
        |=> o_result == {16'h0000, $past(i_dest[15]), $past(i_dest[15:1])})
        else $error("word arith right shift wrong");

    // logical shifts always fill with zero
    lsl_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ7]
        i_valid && i_op == LSB_OP_LOGIC_SHIFT_LEFT_OP && i_size == LSB_SIZE_LONG
        |=> o_result == {$past(i_dest[30:0]), 1'b0}
            && o_carry == $past(i_dest[31]))
        else $error("long logic left shift wrong");

    lsl_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ7]
        i_valid && i_op == LSB_OP_LOGIC_SHIFT_LEFT_OP && i_size == LSB_SIZE_BYTE
        |=> o_result == {24'h00_0000, $past(i_dest[6:0]), 1'b0})
        else $error("byte logic left shift wrong");

    lsr_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ7]
        i_valid && i_op == LSB_OP_LOGIC_SHIFT_RIGHT_OP && i_size == LSB_SIZE_BYTE
        |=> o_result == {24'h00_0000, 1'b0, $past(i_dest[7:1])}
            && o_carry == $past(i_dest[0]))
        else $error("byte logic right shift wrong");

    lsr_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ7]
        i_valid && i_op == LSB_OP_LOGIC_SHIFT_RIGHT_OP && i_size == LSB_SIZE_LONG
        |=> o_result == {1'b0, $past(i_dest[31:1])}
            && o_carry == $past(i_dest[0]))
        else $error("long logic right shift wrong");

    // plain rotates wrap inside the operand width
    rotate_right_op_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ8]
        i_valid && i_op == LSB_OP_ROTATE_RIGHT_OP && i_size == LSB_SIZE_BYTE
        |=> o_result == {24'h00_0000, $past(i_dest[0]), $past(i_dest[7:1])}
            && o_carry == $past(i_dest[0]))
        else $error("byte rotate right wrong");

    rotate_left_op_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ8]
        i_valid && i_op == LSB_OP_ROTATE_LEFT_OP && i_size == LSB_SIZE_WORD
        |=> o_result == {16'h0000, $past(i_dest[14:0]), $past(i_dest[15])}
            && o_carry == $past(i_dest[15]))
        else $error("word rotate left wrong");

    rotate_right_op_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ8]
        i_valid && i_op == LSB_OP_ROTATE_RIGHT_OP && i_size == LSB_SIZE_LONG
        |=> o_result == {$past(i_dest[0]), $past(i_dest[31:1])})
        else $error("long rotate right wrong");

    // rotates through carry: the old flag enters, the pushed-out bit leaves
    rotate_left_carry_op_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ9]
        i_valid && i_op == LSB_OP_ROTATE_LEFT_CARRY_OP && i_size == LSB_SIZE_WORD
        |=> o_result == {16'h0000, $past(i_dest[14:0]), $past(i_carry)}
            && o_carry == $past(i_dest[15]))
        else $error("word rotate left through carry wrong");

    rotate_left_carry_op_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ9]
        i_valid && i_op == LSB_OP_ROTATE_LEFT_CARRY_OP && i_size == LSB_SIZE_BYTE
        |=> o_result == {24'h00_0000, $past(i_dest[6:0]), $past(i_carry)})
        else $error("byte rotate left through carry wrong");

    rotate_right_carry_op_long_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ9]
        i_valid && i_op == LSB_OP_ROTATE_RIGHT_CARRY_OP && i_size == LSB_SIZE_LONG
        |=> o_result == {$past(i_carry), $past(i_dest[31:1])}
            && o_carry == $past(i_dest[0]))
        else $error("long rotate right through carry wrong");

    // bit operations change one bit of the low byte and clear bits 31:8
    bit_set_op_others_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ10]
        i_valid && i_op == LSB_OP_BIT_SET_OP && !i_bit_from_reg
        |=> o_result == {24'h00_0000, $past(i_dest[7:0]) | (8'h01 << $past(i_bit_imm))})
        else $error("bit set disturbed other bits");

    bit_clear_op_others_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ11]
        i_valid && i_op == LSB_OP_BIT_CLEAR_OP && !i_bit_from_reg
        |=> o_result == {24'h00_0000, $past(i_dest[7:0]) & ~(8'h01 << $past(i_bit_imm))})
        else $error("bit clear disturbed other bits");

    bit_clear_op_reg_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ12]
        i_valid && i_op == LSB_OP_BIT_CLEAR_OP && i_bit_from_reg
        |=> o_result[$past(i_source_register[2:0])] == 1'b0)
        else $error("register bit number ignored on clear");

    bit_upper_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ10]
        i_valid && (i_op == LSB_OP_BIT_SET_OP || i_op == LSB_OP_BIT_CLEAR_OP)
        |=> o_result[31:8] == 24'h00_0000)
        else $error("bit op left upper bits");

    // carry flag: written by shift-class ops only, untouched otherwise
    logic_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ14]
        i_valid && i_op <= LSB_OP_NOT
        |=> o_carry == $past(i_carry) && !o_carry_we)
        else $error("logic op moved the carry");

    shift_we_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ14]
        i_valid && i_op >= LSB_OP_ARITH_SHIFT_LEFT_OP && i_op <= LSB_OP_ROTATE_RIGHT_CARRY_OP
        |=> o_valid && o_carry_we)
        else $error("shift did not write carry");

    idle_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RQ14]
        !i_valid
        |=> !o_valid && !o_carry_we && $stable(o_carry)
            && $stable(o_result))
        else $error("outputs moved while idle");

    // main scenarios
    cov_logic_c:  cover property (@(posedge i_clk) i_valid && i_op == LSB_OP_XOR && i_use_imm);
    cov_rotx_c:   cover property (@(posedge i_clk) i_valid && i_op == LSB_OP_ROTATE_LEFT_CARRY_OP);
    cov_bit_clear_op_c:   cover property (@(posedge i_clk) i_valid && i_op == LSB_OP_BIT_CLEAR_OP && i_bit_from_reg);
    cov_b2b_c:    cover property (@(posedge i_clk) i_valid ##1 i_valid);
    cov_asr_c:    cover property (@(posedge i_clk) i_valid && i_op == LSB_OP_ARITH_SHIFT_RIGHT_OP && i_size == LSB_SIZE_WORD);

endmodule
`default_nettype wire

// *** verilog/lsb_pkg.sv ***
package lsb_pkg;

    // operand widths
    localparam int LSB_W = 32;

    // operand size codes
    typedef enum logic [1:0] {
        LSB_SIZE_BYTE = 2'h0,
        LSB_SIZE_WORD = 2'h1,
        LSB_SIZE_LONG = 2'h2
    } lsb_size_e;

    // operation select
    typedef enum logic [3:0] {
        LSB_OP_AND                   = 4'h0,
        LSB_OP_OR                    = 4'h1,
        LSB_OP_XOR                   = 4'h2,
        LSB_OP_NOT                   = 4'h3,
        LSB_OP_ARITH_SHIFT_LEFT_OP   = 4'h4,
        LSB_OP_ARITH_SHIFT_RIGHT_OP  = 4'h5,
        LSB_OP_LOGIC_SHIFT_LEFT_OP   = 4'h6,
        LSB_OP_LOGIC_SHIFT_RIGHT_OP  = 4'h7,
        LSB_OP_ROTATE_LEFT_OP        = 4'h8,
        LSB_OP_ROTATE_RIGHT_OP       = 4'h9,
        LSB_OP_ROTATE_LEFT_CARRY_OP  = 4'ha,
        LSB_OP_ROTATE_RIGHT_CARRY_OP = 4'hb,
        LSB_OP_BIT_SET_OP            = 4'hc,
        LSB_OP_BIT_CLEAR_OP          = 4'hd
    } lsb_op_e;

    // reset values
    localparam logic [31:0] LSB_RESULT_RST = 32'h0000_0000;
    localparam logic        LSB_CARRY_RST  = 1'b0;

    // fixed latency from request to result
    localparam int LSB_LATENCY = 1;

endpackage

// *** verilog/lsb_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
// one-place shift/rotate at the selected width, left ops leave the old top bit just above it at byte and word size; carry out is the bit pushed off
module lsb_shifter
    import lsb_pkg::*;
(
    // operands
    input  wire logic [31:0] i_val,
    input  wire logic [1:0]  i_size,
    input  wire logic [3:0]  i_op,
    input  wire logic        i_carry,
    // results
    output logic      [31:0] o_val,
    output logic             o_carry
);

    logic [4:0] msb;
    logic       top;
    logic       in_bit;

    // top bit index per size
    assign msb = (i_size == LSB_SIZE_BYTE) ? 5'h07 : (i_size == LSB_SIZE_WORD) ? 5'h0f : 5'h1f;
    assign top = i_val[msb];

    // bit fed into the vacated end
    always_comb begin
        unique case (i_op)
            LSB_OP_ARITH_SHIFT_RIGHT_OP:  in_bit = top;      // sign kept [RQ6]
            LSB_OP_ROTATE_LEFT_OP:        in_bit = top;      // [RQ8]
            LSB_OP_ROTATE_RIGHT_OP:       in_bit = i_val[0]; // [RQ8]
            LSB_OP_ROTATE_LEFT_CARRY_OP,
            LSB_OP_ROTATE_RIGHT_CARRY_OP: in_bit = i_carry;  // carry as extra bit [RQ9]
            default:                      in_bit = 1'b0;     // plain shifts fill zero [RQ6] [RQ7]
        endcase
    end

    // left ops shift up, right ops place in_bit at the top of the operand
    logic left;
    assign left = (i_op == LSB_OP_ARITH_SHIFT_LEFT_OP) || (i_op == LSB_OP_LOGIC_SHIFT_LEFT_OP)
               || (i_op == LSB_OP_ROTATE_LEFT_OP) || (i_op == LSB_OP_ROTATE_LEFT_CARRY_OP);

    always_comb begin
        o_val = 32'h0000_0000;
        if (left) begin
            o_val = {i_val[30:0], in_bit};
        end else begin
            o_val = {1'b0, i_val[31:1]};
            o_val[msb] = in_bit;
        end
        o_carry = left ? top : i_val[0]; // [RQ14]
    end

endmodule
`default_nettype wire
